// [hdl/pin_unit.sv]
// general-purpose pin unit: digital io, pwm, analog sample, touch, buttons
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module pin_unit
   import pin_unit_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [NUM_PINS-1:0] pin_in,
   output logic      [NUM_PINS-1:0] pin_out,
   output logic      [NUM_PINS-1:0] pin_oe,
   output logic      [NUM_PINS-1:0] pull_up_en,
   output logic      [NUM_PINS-1:0] pull_dn_en,
   input  wire logic [1:0]          button_n,
   output logic                     adc_start,
   output logic      [4:0]          adc_chan,
   input  wire logic                adc_done,
   input  wire logic [9:0]          adc_value,
   output logic                     irq
);
   if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
      $error("CNT_W must lie in 1..32");
   end

   // ============================================================
   // input synchronisers
   logic [NUM_PINS-1:0] pin_m_q, pin_s_q;
   logic [1:0]          btn_m_q, btn_s_q, btn_prev_q;
   always_ff @(posedge clk_sys) begin
      pin_m_q <= pin_in;
      pin_s_q <= pin_m_q;
      btn_m_q <= ~button_n;
      btn_s_q <= btn_m_q;
   end

   // ============================================================
   // bus decode
   logic        acc, wr_fire, rd_fire, ready_q, err_d;
   logic [31:0] rdata_d;
   logic [4:0]  sel_q;
   pin_cap_e    sel_cap;
   logic [2:0]  cmd;
   logic [1:0]  press;
   assign acc     = psel && penable && !ready_q;
   assign wr_fire = acc && pwrite && !err_d;
   assign rd_fire = acc && !pwrite && !err_d;
   assign sel_cap = pin_cap({27'h0, sel_q});
   assign cmd     = pwdata[CTRL_CMD_LSB +: 3];
   assign press   = btn_s_q & ~btn_prev_q;

   pin_cfg_s              cfg_q [NUM_PINS];
   logic [9:0]            duty_q [NUM_PINS];
   logic [9:0]            duty_act_q [NUM_PINS];
   logic [19:0]           period_q, period_act_q, pcnt_q;
   logic [9:0]            adc_data_q;
   logic                  adc_busy_q;
   logic [1:0]            was_q;
   logic [CNT_W-1:0]      cnt_q [2];
   logic [IRQ_W-1:0]      stat_q, mask_q;
   logic [IRQ_W-1:0]      evt;
   assign evt = {adc_done && adc_busy_q, press};

   function automatic logic cmd_ok(input pin_cap_e c, input logic [2:0] k,
                                   input logic [1:0] p);
      logic ok;
      ok = 1'b0;
      unique case (k)
         CMD_DIN, CMD_DOUT: ok = (c != CAP_NONE);
         CMD_AIN:           ok = (c >= CAP_ANA);
         CMD_TOUCH:         ok = (c == CAP_TOUCH);
         CMD_PULL:          ok = (c != CAP_NONE) && (p != 2'h3);
         default:           ok = 1'b0;
      endcase
      return ok;
   endfunction : cmd_ok

   // errors: unmapped offsets, absent pins, bad commands, short periods
   always_comb begin
      err_d = 1'b0;
      unique case (paddr)
         OFS_SEL:      err_d = pwrite && (pin_cap(pwdata) == CAP_NONE);
         OFS_CTRL:     err_d = pwrite && !cmd_ok(sel_cap, cmd, pwdata[CTRL_PULL_LSB +: 2]);
         OFS_LEVEL:    err_d = (sel_cap == CAP_NONE);
         OFS_TOUCH:    err_d = (sel_cap != CAP_TOUCH);
         OFS_DUTY:     err_d = pwrite && (sel_cap < CAP_ANA || pwdata > {22'h0, DUTY_MAX});
         OFS_PER_MS:   err_d = pwrite && (pwdata < PERIOD_MIN_MS || pwdata > PERIOD_MAX_MS);
         OFS_PER_US:   err_d = pwrite && (pwdata < PERIOD_MIN_US || pwdata > PERIOD_MAX_US);
         OFS_ANALOG:   err_d = pwrite && (sel_cap < CAP_ANA);
         OFS_BTN_LVL, OFS_BTN_WAS, OFS_CNT_A, OFS_CNT_B,
         OFS_IRQ_STAT, OFS_IRQ_MASK: err_d = 1'b0;
         default:      err_d = 1'b1;
      endcase
   end

   always_comb begin
      rdata_d = 32'h0;
      unique case (paddr)
         OFS_SEL:      rdata_d = {27'h0, sel_q};
         OFS_CTRL:     rdata_d = {23'h0, cfg_q[sel_q].level, 2'b0,
                                  cfg_q[sel_q].pull, 1'b0, cfg_q[sel_q].mode};
         OFS_LEVEL:    rdata_d = {31'h0, pin_s_q[sel_q]};
         OFS_TOUCH:    rdata_d = {31'h0, !pin_s_q[sel_q]};
         OFS_DUTY:     rdata_d = {22'h0, duty_q[sel_q]};
         OFS_PER_MS, OFS_PER_US: rdata_d = {12'h0, period_q};
         OFS_ANALOG:   rdata_d = {15'h0, adc_busy_q, 6'h0, adc_data_q};
         OFS_BTN_LVL:  rdata_d = {30'h0, btn_s_q};
         OFS_BTN_WAS:  rdata_d = {30'h0, was_q};
         OFS_CNT_A:    rdata_d = 32'(cnt_q[0]);
         OFS_CNT_B:    rdata_d = 32'(cnt_q[1]);
         OFS_IRQ_STAT: rdata_d = {29'h0, stat_q};
         OFS_IRQ_MASK: rdata_d = {29'h0, mask_q};
         default:      rdata_d = 32'h0;
      endcase
   end

   // every access answers in its second access cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ready_q <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         ready_q <= acc;
         pslverr <= acc && err_d;
         if (acc && !pwrite && !err_d) prdata <= rdata_d;
      end
   end
   assign pready = ready_q;

   // ============================================================
   // pin selection and per-pin configuration
   always_ff @(posedge clk_sys) begin
      if (!rst_n) sel_q <= 5'h0;
      else if (wr_fire && paddr == OFS_SEL) sel_q <= pwdata[4:0];
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            cfg_q[i]  <= CFG_RST;
            duty_q[i] <= 10'h000;
         end
      end else if (wr_fire && paddr == OFS_CTRL) begin
         unique case (cmd)
            CMD_DIN:   cfg_q[sel_q] <= '{MODE_DIN, PULL_DOWN, 1'b0};
            CMD_DOUT:  cfg_q[sel_q] <= '{MODE_DOUT, PULL_NONE, pwdata[CTRL_VAL_BIT]};
            CMD_AIN:   cfg_q[sel_q] <= '{MODE_AIN, PULL_NONE, 1'b0};
            CMD_TOUCH: cfg_q[sel_q] <= '{MODE_TOUCH, PULL_UP, 1'b0};
            CMD_PULL:  cfg_q[sel_q] <= '{MODE_DIN, pull_e'(pwdata[CTRL_PULL_LSB +: 2]), 1'b0};
            default:   cfg_q[sel_q] <= cfg_q[sel_q];
         endcase
      end else if (wr_fire && paddr == OFS_DUTY) begin
         cfg_q[sel_q]  <= '{MODE_PWM, PULL_NONE, 1'b0};
         duty_q[sel_q] <= pwdata[9:0];
      end else if (wr_fire && paddr == OFS_ANALOG) begin
         cfg_q[sel_q] <= '{MODE_AIN, PULL_NONE, 1'b0};
      end else if (rd_fire && paddr == OFS_LEVEL && cfg_q[sel_q].mode != MODE_DIN) begin
         // keep a pull chosen earlier if the pin already samples digitally
         cfg_q[sel_q] <= '{MODE_DIN, PULL_DOWN, 1'b0};
      end else if (rd_fire && paddr == OFS_TOUCH) begin
         cfg_q[sel_q] <= '{MODE_TOUCH, PULL_UP, 1'b0};
      end
   end

   // ============================================================
   // pwm timebase: 1 us tick, shared period, per-pin duty
   logic [4:0] tick_q;
   logic       tick;
   assign tick = (tick_q == 5'(TICK_CYCLES - 1));
   always_ff @(posedge clk_sys) begin
      if (!rst_n) tick_q <= 5'h0;
      else tick_q <= tick ? 5'h0 : tick_q + 5'h1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) period_q <= PERIOD_RST_US;
      else if (wr_fire && paddr == OFS_PER_MS) period_q <= 20'(pwdata * US_PER_MS);
      else if (wr_fire && paddr == OFS_PER_US) period_q <= pwdata[19:0];
   end

   logic wrap;
   assign wrap = tick && (pcnt_q >= period_act_q - 20'h1);
   // shadow copies load only at the wrap so a running pulse is never cut
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pcnt_q       <= 20'h0;
         period_act_q <= PERIOD_RST_US;
         for (int i = 0; i < NUM_PINS; i++) duty_act_q[i] <= 10'h000;
      end else if (wrap) begin
         pcnt_q       <= 20'h0;
         period_act_q <= period_q;
         duty_act_q   <= duty_q;
      end else if (tick) begin
         pcnt_q <= pcnt_q + 20'h1;
      end
   end

   // high while count*1023 < duty*period: 0 never high, 1023 always high
   function automatic logic pwm_hi(input logic [19:0] c, input logic [9:0] d,
                                   input logic [19:0] p);
      return ({10'h0, c} * {20'h0, DUTY_MAX}) < ({20'h0, d} * {10'h0, p});
   endfunction : pwm_hi

   // ============================================================
   // pin drivers and pulls
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_out    <= '0;
         pin_oe     <= '0;
         pull_up_en <= '0;
         pull_dn_en <= '0;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (pin_cap(i) == CAP_NONE) begin
               pin_out[i]    <= 1'b0;
               pin_oe[i]     <= 1'b0;
               pull_up_en[i] <= 1'b0;
               pull_dn_en[i] <= 1'b0;
            end else begin
               pin_oe[i]     <= cfg_q[i].mode inside {MODE_DOUT, MODE_PWM};
               pin_out[i]    <= (cfg_q[i].mode == MODE_DOUT) ? cfg_q[i].level :
                                (cfg_q[i].mode == MODE_PWM) &&
                                pwm_hi(pcnt_q, duty_act_q[i], period_act_q);
               pull_up_en[i] <= !pin_oe[i] && cfg_q[i].pull == PULL_UP;
               pull_dn_en[i] <= !pin_oe[i] && cfg_q[i].pull == PULL_DOWN;
            end
         end
      end
   end

   // ============================================================
   // analog sample request
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         adc_start  <= 1'b0;
         adc_chan   <= 5'h0;
         adc_busy_q <= 1'b0;
         adc_data_q <= 10'h000;
      end else begin
         adc_start <= wr_fire && paddr == OFS_ANALOG && !adc_busy_q;
         if (wr_fire && paddr == OFS_ANALOG && !adc_busy_q) begin
            adc_chan   <= sel_q;
            adc_busy_q <= 1'b1;
         end else if (adc_done && adc_busy_q) begin
            adc_busy_q <= 1'b0;
            adc_data_q <= adc_value;
         end
      end
   end

   // ============================================================
   // buttons: a press that lands on the clearing read still counts
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         btn_prev_q <= 2'b00;
         was_q      <= 2'b00;
      end else begin
         btn_prev_q <= btn_s_q;
         was_q      <= (rd_fire && paddr == OFS_BTN_WAS) ? press : was_q | press;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_q[0] <= '0;
         cnt_q[1] <= '0;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (rd_fire && paddr == (b == 0 ? OFS_CNT_A : OFS_CNT_B))
               cnt_q[b] <= CNT_W'(press[b]);
            else if (press[b] && cnt_q[b] != '1)
               cnt_q[b] <= cnt_q[b] + CNT_W'(1);
         end
      end
   end

   // ============================================================
   // interrupts
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stat_q <= '0;
         mask_q <= '0;
         irq    <= 1'b0;
      end else begin
         stat_q <= ((rd_fire && paddr == OFS_IRQ_STAT) ? '0 : stat_q) | evt;
         if (wr_fire && paddr == OFS_IRQ_MASK) mask_q <= pwdata[IRQ_W-1:0];
         irq <= |(stat_q & mask_q);
      end
   end

   // ============================================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   apb_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered in second cycle");

   bad_addr_a: assert property (acc && paddr > OFS_IRQ_MASK |=> pready && pslverr)
      else $error("unmapped address not refused");

   short_ms_a: assert property (acc && pwrite && paddr == OFS_PER_MS && pwdata == 32'h0
      |=> pslverr && period_q == $past(period_q))
      else $error("zero ms period accepted");

   short_us_a: assert property (acc && pwrite && paddr == OFS_PER_US && pwdata == 32'h0FF
      |=> pslverr && period_q == $past(period_q))
      else $error("255 us period accepted");

   dout_drive_a: assert property (wr_fire && paddr == OFS_CTRL && cmd == CMD_DOUT
      && sel_q == 5'h5 |=> ##1 pin_oe[5] && pin_out[5] == $past(pwdata[CTRL_VAL_BIT], 2))
      else $error("digital output not driven as written");

   touch_pull_a: assert property (wr_fire && paddr == OFS_CTRL && cmd == CMD_TOUCH
      && sel_q == 5'h0 |=> ##1 pull_up_en[0] && !pull_dn_en[0])
      else $error("touch mode without pull-up");

   pwm_full_a: assert property (cfg_q[4].mode == MODE_PWM && duty_act_q[4] == DUTY_MAX
      && $stable(duty_act_q[4]) |=> pin_out[4])
      else $error("full duty pwm went low");

   duty_hold_a: assert property (!wrap |=> duty_act_q[4] == $past(duty_act_q[4]))
      else $error("duty changed inside a period");

   was_clear_a: assert property (rd_fire && paddr == OFS_BTN_WAS && press == 2'b00
      |=> was_q == 2'b00 && prdata[1:0] == $past(was_q))
      else $error("pressed flag survived its read");

   cnt_clear_a: assert property (rd_fire && paddr == OFS_CNT_A && !press[0]
      |=> cnt_q[0] == '0)
      else $error("press count not cleared by read");

   absent_pin_a: assert property (!pin_oe[17] && !pin_oe[18] && !pull_up_en[17]
      && !pull_dn_en[18])
      else $error("absent pin driven");

   sel_absent_a: assert property (acc && pwrite && paddr == OFS_SEL && pwdata == 32'h11
      |=> pslverr && sel_q == $past(sel_q))
      else $error("absent pin selected");

   ain_pull_a: assert property (wr_fire && paddr == OFS_CTRL && cmd == CMD_AIN
      && sel_q == 5'h3 |=> ##1 !pull_up_en[3] && !pull_dn_en[3])
      else $error("analog mode kept a pull");

   pull_cmd_a: assert property (wr_fire && paddr == OFS_CTRL && cmd == CMD_PULL
      && sel_q == 5'h0 |=> cfg_q[0].mode == MODE_DIN
      && cfg_q[0].pull == $past(pwdata[CTRL_PULL_LSB +: 2]))
      else $error("pull command missed digital input");

   touch_read_a: assert property (rd_fire && paddr == OFS_TOUCH
      |=> prdata[0] == !$past(pin_s_q[sel_q]))
      else $error("touch read wrong");

   no_pull_drive_a: assert property (!(|(pin_oe & (pull_up_en | pull_dn_en))))
      else $error("pull left on a driven pin");

   stat_clear_a: assert property (rd_fire && paddr == OFS_IRQ_STAT && evt == '0
      |=> stat_q == '0)
      else $error("status survived its read");

   adc_kick_a: assert property (wr_fire && paddr == OFS_ANALOG && !adc_busy_q
      |=> adc_start && adc_chan == $past(sel_q))
      else $error("sample not started on selected pin");
endmodule : pin_unit
`default_nettype wire

// [hdl/pin_unit_pkg.sv]
// constants, types and helpers shared by the pin unit
// ============================================================
// Notes on behaviour
// - a sampled pin level reads 1 when high and 0 when low
// - digital output drives the pin high for value 1, low for 0
// - PWM duty is proportional to value, 0 is 0 percent, 1023 is 100 percent
// - PWM period may be set in milliseconds, never below 1 ms
// - PWM period may be set in microseconds, never below 256 us
// - analog sample returns 0 for zero volts up to 1023 for full supply
// - entering any input mode sets the pin pull automatically
// - default pulls: none for analog, down for digital, up for touch
// - explicit pull command puts pin in digital input with given pull
// - touch test reports true when pin-to-ground resistance is low
// - button level reads true while that button is held down
// - sticky pressed flag per button, set by a press, cleared on read
// - press count per button, read returns it and clears it
// - nineteen usable pins; indices 17 and 18 are never accessible
// - touch pins do everything analog pins do, analog pins all digital
package pin_unit_pkg;
   localparam int NUM_PINS = 21;
   localparam int CLK_HZ = 25_000_000;
   localparam int HZ_PER_MHZ = 1_000_000;
   localparam int TICK_CYCLES = CLK_HZ / HZ_PER_MHZ;
   localparam int US_PER_MS = 1000;
   localparam logic [31:0] PERIOD_MIN_MS = 32'h0000_0001;
   localparam logic [31:0] PERIOD_MIN_US = 32'h0000_0100;
   localparam logic [31:0] PERIOD_MAX_MS = 32'h0000_0418;
   localparam logic [31:0] PERIOD_MAX_US = 32'h000F_FFFF;
   localparam logic [19:0] PERIOD_RST_US = 20'h003E8;
   localparam logic [9:0] DUTY_MAX = 10'h3FF;
   // register byte offsets
   localparam logic [7:0] OFS_SEL = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_LEVEL = 8'h08;
   localparam logic [7:0] OFS_TOUCH = 8'h0C;
   localparam logic [7:0] OFS_DUTY = 8'h10;
   localparam logic [7:0] OFS_PER_MS = 8'h14;
   localparam logic [7:0] OFS_PER_US = 8'h18;
   localparam logic [7:0] OFS_ANALOG = 8'h1C;
   localparam logic [7:0] OFS_BTN_LVL = 8'h20;
   localparam logic [7:0] OFS_BTN_WAS = 8'h24;
   localparam logic [7:0] OFS_CNT_A = 8'h28;
   localparam logic [7:0] OFS_CNT_B = 8'h2C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
   // control word fields and analog register busy bit
   localparam int CTRL_CMD_LSB = 0;
   localparam int CTRL_PULL_LSB = 4;
   localparam int CTRL_VAL_BIT = 8;
   localparam int ANALOG_BUSY_BIT = 16;
   localparam logic [2:0] CMD_DIN = 3'h0;
   localparam logic [2:0] CMD_DOUT = 3'h1;
   localparam logic [2:0] CMD_AIN = 3'h2;
   localparam logic [2:0] CMD_TOUCH = 3'h3;
   localparam logic [2:0] CMD_PULL = 3'h4;
   // interrupt status bits
   localparam int IRQ_BTN_A = 0;
   localparam int IRQ_BTN_B = 1;
   localparam int IRQ_ADC = 2;
   localparam int IRQ_W = 3;

   typedef enum logic [2:0] {MODE_DIN, MODE_DOUT, MODE_AIN, MODE_PWM, MODE_TOUCH} pin_mode_e;
   typedef enum logic [1:0] {PULL_NONE, PULL_DOWN, PULL_UP} pull_e;
   typedef struct packed {
      pin_mode_e mode;
      pull_e     pull;
      logic      level;
   } pin_cfg_s;
   localparam pin_cfg_s CFG_RST = '{mode: MODE_DIN, pull: PULL_DOWN, level: 1'b0};

   typedef enum logic [1:0] {CAP_NONE, CAP_DIG, CAP_ANA, CAP_TOUCH} pin_cap_e;

   // capability of each index; classes nest so a higher one covers the lower
   function automatic pin_cap_e pin_cap(input logic [31:0] idx);
      pin_cap_e c;
      c = CAP_NONE;
      if (idx <= 32'h0000_0002) c = CAP_TOUCH;
      else if (idx <= 32'h0000_0004 || idx == 32'h0000_000A) c = CAP_ANA;
      else if (idx <= 32'h0000_0010 || idx == 32'h0000_0013 || idx == 32'h0000_0014) c = CAP_DIG;
      return c;
   endfunction : pin_cap
endpackage : pin_unit_pkg

// [verification/pin_unit_tb.sv]
// self-checking bench for the pin unit
`timescale 1ns/10ps
`default_nettype none
module pin_unit_tb
   import pin_unit_pkg::*;
;
   logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, adc_start, adc_done, irq;
   logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe, pull_up_en, pull_dn_en;
   logic [NUM_PINS-1:0] ext_drv = '0, ext_val = '0;
   logic [1:0] btn_hold = 2'h0, button_n;
   logic [4:0] adc_chan;
   logic [9:0] adc_value, ana_val = 10'h000;
   int errors = 0, compares = 0, cyc = 0;
   pin_unit #(.CNT_W(16)) u_pin_unit (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .button_n(button_n),
      .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
      .adc_value(adc_value), .irq(irq));
   pin_world u_pin_world (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
      .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .ext_drv(ext_drv), .ext_val(ext_val),
      .btn_hold(btn_hold), .adc_start(adc_start), .ana_val(ana_val), .pin_in(pin_in),
      .button_n(button_n), .adc_done(adc_done), .adc_value(adc_value));
   initial forever #20 clk_sys = ~clk_sys;
   // ============================================================
   // shared tasks
   task test_done;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : idle
   // pready is sampled as it stood before the edge, so no race with the design
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 50) chk("pready", 32'h1, 32'h0);
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk("pslverr", {31'h0, e}, {31'h0, er});
   endtask : wr
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, x, rd & m);
   endtask : rdc
   // ============================================================
   // scenarios
   task t_reset;
      chk("pin_oe", 32'h0, {11'h0, pin_oe});
      chk("pull_up", 32'h0, {11'h0, pull_up_en});
      chk("pull_dn", 32'h0019_FFFF, {11'h0, pull_dn_en});
   endtask : t_reset
   task t_period;
      wr(OFS_PER_MS, 32'h0, 1'b1);
      wr(OFS_PER_MS, 32'h1, 1'b0);
      rdc("per_ms", OFS_PER_MS, 32'hFFFF_FFFF, 32'h3E8);
      wr(OFS_PER_US, 32'hFF, 1'b1);
      wr(OFS_PER_US, 32'h100, 1'b0);
      rdc("per_us", OFS_PER_US, 32'hFFFF_FFFF, 32'h100);
      wr(OFS_SEL, 32'h4, 1'b0);
      wr(OFS_DUTY, 32'h400, 1'b1);
      wr(OFS_DUTY, 32'h1FF, 1'b0);
   endtask : t_period
   task t_digital;
      wr(OFS_SEL, 32'h5, 1'b0);
      wr(OFS_CTRL, 32'h101, 1'b0);
      idle(3);
      chk("out5", 32'h3, {30'h0, pin_oe[5], pin_out[5]});
      wr(OFS_CTRL, 32'h1, 1'b0);
      idle(3);
      chk("out5", 32'h2, {30'h0, pin_oe[5], pin_out[5]});
      wr(OFS_SEL, 32'h6, 1'b0);
      ext_drv[6] <= 1'b1; ext_val[6] <= 1'b1;
      idle(4);
      rdc("level", OFS_LEVEL, 32'h1, 32'h1);
      ext_val[6] <= 1'b0;
      idle(4);
      rdc("level", OFS_LEVEL, 32'h1, 32'h0);
   endtask : t_digital
   task t_pulls;
      wr(OFS_SEL, 32'h3, 1'b0);
      wr(OFS_CTRL, {29'h0, CMD_AIN}, 1'b0);
      idle(3);
      chk("pulls3", 32'h0, {30'h0, pull_up_en[3], pull_dn_en[3]});
      wr(OFS_SEL, 32'h0, 1'b0);
      wr(OFS_CTRL, {29'h0, CMD_TOUCH}, 1'b0);
      idle(4);
      chk("pulls0", 32'h2, {30'h0, pull_up_en[0], pull_dn_en[0]});
      rdc("touch", OFS_TOUCH, 32'h1, 32'h0);
      ext_drv[0] <= 1'b1;
      idle(4);
      rdc("touch", OFS_TOUCH, 32'h1, 32'h1);
      ext_drv[0] <= 1'b0;
      wr(OFS_CTRL, 32'h24, 1'b0);
      idle(3);
      rdc("ctrl", OFS_CTRL, 32'hFF, 32'h20);
      chk("pulls0", 32'h2, {30'h0, pull_up_en[0], pull_dn_en[0]});
      wr(OFS_CTRL, {29'h0, CMD_AIN}, 1'b0);
      apb(1'b0, OFS_LEVEL, 32'h0);
      idle(3);
      chk("pulls0", 32'h1, {30'h0, pull_up_en[0], pull_dn_en[0]});
      wr(OFS_CTRL, 32'h34, 1'b1);
      wr(OFS_SEL, 32'h5, 1'b0);
      wr(OFS_CTRL, {29'h0, CMD_TOUCH}, 1'b1);
      wr(OFS_SEL, 32'hA, 1'b0);
      wr(OFS_CTRL, {29'h0, CMD_DOUT}, 1'b0);
      wr(OFS_CTRL, {29'h0, CMD_DIN}, 1'b0);
      idle(3);
      chk("pins10", 32'h1, {30'h0, pin_oe[10], pull_dn_en[10]});
      wr(OFS_SEL, 32'h11, 1'b1);
      wr(OFS_SEL, 32'h12, 1'b1);
      wr(OFS_SEL, 32'h13, 1'b0);
      wr(8'h3C, 32'h0, 1'b1);
   endtask : t_pulls
   task t_adc;
      logic [9:0] vals [3];
      int n;
      vals = '{10'h000, 10'h2A5, 10'h3FF};
      wr(OFS_SEL, 32'h3, 1'b0);
      for (int i = 0; i < 3; i++) begin
         ana_val <= vals[i];
         wr(OFS_IRQ_MASK, (i == 2) ? 32'h4 : 32'h0, 1'b0);
         wr(OFS_ANALOG, 32'h0, 1'b0);
         n = 0;
         do begin
            apb(1'b0, OFS_ANALOG, 32'h0);
            n++;
         end while (rd[16] !== 1'b0 && n < 30);
         chk("adc", {22'h0, vals[i]}, rd & 32'h3FF);
         chk("irq", (i == 2) ? 32'h1 : 32'h0, {31'h0, irq});
         rdc("stat", OFS_IRQ_STAT, 32'h7, 32'h4);
      end
      idle(3);
      chk("irq", 32'h0, {31'h0, irq});
      chk("adc_chan", 32'h3, {27'h0, adc_chan});
   endtask : t_adc
   task t_buttons;
      btn_hold[0] <= 1'b1;
      idle(8);
      btn_hold[0] <= 1'b0;
      idle(8);
      btn_hold[0] <= 1'b1;
      idle(8);
      rdc("btn_lvl", OFS_BTN_LVL, 32'h3, 32'h1);
      btn_hold <= 2'b10;
      idle(8);
      btn_hold[1] <= 1'b0;
      idle(8);
      rdc("btn_lvl", OFS_BTN_LVL, 32'h3, 32'h0);
      rdc("btn_was", OFS_BTN_WAS, 32'h3, 32'h3);
      rdc("btn_was", OFS_BTN_WAS, 32'h3, 32'h0);
      rdc("cnt_a", OFS_CNT_A, 32'hFFFF, 32'h2);
      rdc("cnt_a", OFS_CNT_A, 32'hFFFF, 32'h0);
      rdc("cnt_b", OFS_CNT_B, 32'hFFFF, 32'h1);
      rdc("stat", OFS_IRQ_STAT, 32'h7, 32'h3);
   endtask : t_buttons
   // one full 256 us period is 6400 clocks; any aligned window sees one period
   task t_pwm;
      logic [31:0] duty [3], high [3];
      int h, n;
      duty = '{32'h1FF, 32'h3FF, 32'h0};
      high = '{32'd3200, 32'd6400, 32'd0};
      n = 0;
      while (pin_out[4] !== 1'b1 && n < 30000) begin
         @(posedge clk_sys);
         n++;
      end
      wr(OFS_SEL, 32'h4, 1'b0);
      for (int i = 0; i < 3; i++) begin
         wr(OFS_DUTY, duty[i], 1'b0);
         idle(6500);
         h = 0;
         repeat (6400) begin
            @(posedge clk_sys);
            if (pin_out[4] === 1'b1) h++;
         end
         chk("pwm_high", high[i], h);
      end
   endtask : t_pwm
   // ============================================================
   // main sequence and hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         errors++;
         test_done;
      end
   end
   initial begin
      idle(8);
      rst_n <= 1'b1;
      idle(3);
      t_reset;
      t_period;
      t_digital;
      t_pulls;
      t_adc;
      t_buttons;
      t_pwm;
      test_done;
   end
endmodule : pin_unit_tb
`default_nettype wire

// [verification/pin_world.sv]
// far-side model: pin loads, push buttons and analog converter
`timescale 1ns/10ps
`default_nettype none
module pin_world
   import pin_unit_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic [NUM_PINS-1:0] pin_out,
   input  wire logic [NUM_PINS-1:0] pin_oe,
   input  wire logic [NUM_PINS-1:0] pull_up_en,
   input  wire logic [NUM_PINS-1:0] pull_dn_en,
   input  wire logic [NUM_PINS-1:0] ext_drv,
   input  wire logic [NUM_PINS-1:0] ext_val,
   input  wire logic [1:0]          btn_hold,
   input  wire logic                adc_start,
   input  wire logic [9:0]          ana_val,
   output logic      [NUM_PINS-1:0] pin_in,
   output logic      [1:0]          button_n,
   output logic                     adc_done,
   output logic      [9:0]          adc_value
);
   // ============================================================
   // pin wire level
   logic [NUM_PINS-1:0] last_q = '0;
   logic [4:0]          wait_q = 5'h00;
   logic                done_q = 1'b0;
   logic [9:0]          val_q  = 10'h000;
   // a finger is a low resistance to ground, seen as an external low drive
   // a floating pin shows the inverse of its last level, never a kept value
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
                 | (~pin_oe & ~ext_drv & (pull_up_en | (~pull_dn_en & ~last_q)));
   assign button_n = ~btn_hold;
   always @(posedge clk_sys) begin
      last_q <= pin_in;
   end
   // ============================================================
   // converter: answers twelve cycles after a start, garbage otherwise
   always @(posedge clk_sys) begin
      if (adc_start) wait_q <= 5'h0C;
      else if (wait_q != 5'h00) wait_q <= wait_q - 5'h01;
      done_q <= (wait_q == 5'h01);
      val_q  <= (wait_q == 5'h01) ? ana_val : ~val_q;
   end
   assign adc_done  = done_q;
   assign adc_value = val_q;
endmodule : pin_world
`default_nettype wire
